// ---- rtl/acs_regs.vh ----
// Register offsets, field positions and codes for the converter control block.
`ifndef ACS_REGS_VH
`define ACS_REGS_VH
`define ACS_OFF_STATUS 5'h00
`define ACS_OFF_CLKSEL 5'h04
`define ACS_OFF_REFSEL 5'h08
`define ACS_OFF_CHSEL 5'h0c
`define ACS_OFF_EVENTS 5'h10
`define ACS_RESET_BYTE 8'h00
`define ACS_BIT_OVF 7
`define ACS_BIT_UPPER 6
`define ACS_BIT_LOWER 5
`define ACS_BIT_COMPUTATION_UPDATED_FLAG 4
`define ACS_BIT_NEGATIVE_REFERENCE_SELECT 4
`define ACS_BIT_RSVD 3
`define ACS_MASK_CLK 8'h3f
`define ACS_MASK_REF 8'h13
`define ACS_MASK_CH 8'h3f
`define ACS_MASK_STAT 8'hf7
`define ACS_STG_IDLE 3'h0
`define ACS_STG_PRE1 3'h1
`define ACS_STG_ACQ1 3'h2
`define ACS_STG_CNV1 3'h3
`define ACS_STG_UNUSED 3'h4
`define ACS_STG_PRE2 3'h5
`define ACS_STG_ACQ2 3'h6
`define ACS_STG_CNV2 3'h7
`define ACS_POSITIVE_REFERENCE_SELECT_VDD 2'h0
`define ACS_POSITIVE_REFERENCE_SELECT_RSVD 2'h1
`define ACS_POSITIVE_REFERENCE_SELECT_EXT 2'h2
`define ACS_POSITIVE_REFERENCE_SELECT_FVR 2'h3
`define ACS_CH_E_LAST 6'h22
`define ACS_CH_F_FIRST 6'h28
`define ACS_CH_F_LAST 6'h2f
`define ACS_CH_GND 6'h3c
`define ACS_CH_TEMP 6'h3d
`define ACS_CH_DAC 6'h3e
`define ACS_CH_FVR 6'h3f
`define ACS_CH_D_LAST 6'h1f
`define ACS_RESP_OKAY 2'h0
`define ACS_RESP_SLVERR 2'h2
`endif

// ---- rtl/acs_clkdiv.v ----
// Even-ratio conversion clock divider.
`timescale 1ns/1ps
module acs_clkdiv #(
  parameter SEL_W = 6
) (
  mclk,
  nrst,
  sel,
  conv_clk,
  conv_tick
);
  input wire mclk;
  input wire nrst;
  input wire [SEL_W-1:0] sel;
  output reg conv_clk;
  output reg conv_tick;
  reg [SEL_W-1:0] half_q;
  // Each half period lasts sel+1 cycles, giving a divide by 2*sel+2.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      half_q <= {SEL_W{1'b0}};
      conv_clk <= 1'b0;
      conv_tick <= 1'b0;
    end else if (half_q >= sel) begin
      half_q <= {SEL_W{1'b0}};
      conv_clk <= ~conv_clk;
      conv_tick <= ~conv_clk;
    end else begin
      half_q <= half_q + {{(SEL_W-1){1'b0}}, 1'b1};
      conv_tick <= 1'b0;
    end
  end
endmodule

// ---- rtl/acs_top.v ----
// Converter status, clock, reference and channel select registers.
`timescale 1ns/1ps
`include "acs_regs.vh"
module acs_top #(
  parameter ADDR_W = 5
) (
  mclk,
  nrst,
  s_axi_awaddr,
  s_axi_awvalid,
  s_axi_awready,
  s_axi_wdata,
  s_axi_wstrb,
  s_axi_wvalid,
  s_axi_wready,
  s_axi_bresp,
  s_axi_bvalid,
  s_axi_bready,
  s_axi_araddr,
  s_axi_arvalid,
  s_axi_arready,
  s_axi_rdata,
  s_axi_rresp,
  s_axi_rvalid,
  s_axi_rready,
  acc_overflow,
  err_overflow,
  err_above_upper,
  err_below_lower,
  computation_updated_flag_update,
  stage_code,
  rc_slow_sysclk,
  conv_clk,
  neg_ref_ext,
  pos_ref_sel,
  pos_ref_valid,
  chan_sel,
  chan_valid,
  chan_port,
  chan_index,
  stage_suspect
);
  input wire mclk;
  input wire nrst;
  input wire [ADDR_W-1:0] s_axi_awaddr;
  input wire s_axi_awvalid;
  output reg s_axi_awready;
  input wire [31:0] s_axi_wdata;
  input wire [3:0] s_axi_wstrb;
  input wire s_axi_wvalid;
  output reg s_axi_wready;
  output reg [1:0] s_axi_bresp;
  output reg s_axi_bvalid;
  input wire s_axi_bready;
  input wire [ADDR_W-1:0] s_axi_araddr;
  input wire s_axi_arvalid;
  output reg s_axi_arready;
  output reg [31:0] s_axi_rdata;
  output reg [1:0] s_axi_rresp;
  output reg s_axi_rvalid;
  input wire s_axi_rready;
  input wire acc_overflow;
  input wire err_overflow;
  input wire err_above_upper;
  input wire err_below_lower;
  input wire computation_updated_flag_update;
  input wire [2:0] stage_code;
  input wire rc_slow_sysclk;
  output wire conv_clk;
  output reg neg_ref_ext;
  output reg [1:0] pos_ref_sel;
  output reg pos_ref_valid;
  output reg [5:0] chan_sel;
  output reg chan_valid;
  output reg [2:0] chan_port;
  output reg [2:0] chan_index;
  output reg stage_suspect;

  reg [7:0] clk_q;
  reg [7:0] ref_q;
  reg [7:0] ch_q;
  reg computation_updated_flag_q;
  reg [7:0] stat_q;
  reg aw_hold_q;
  reg w_hold_q;
  reg [ADDR_W-1:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg [7:0] ev_q;
  wire computation_updated_flag_clr;
  wire do_write;
  wire [ADDR_W-1:0] wr_addr;
  wire [31:0] wr_data;
  wire [3:0] wr_strb;
  wire ch_ok;
  wire [5:0] ch_d;
  reg [31:0] rd_d;
  reg rd_ok;
  reg wr_ok;

  // Level inputs from the computation path cross through two stages.
  reg [7:0] sync1_q;
  reg [7:0] sync2_q;
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      sync1_q <= `ACS_RESET_BYTE;
      sync2_q <= `ACS_RESET_BYTE;
    end else begin
      sync1_q <= {acc_overflow, err_overflow, err_above_upper,
                  err_below_lower, computation_updated_flag_update, stage_code};
      sync2_q <= sync1_q;
    end
  end
  reg computation_updated_flag_prev_q;
  reg rcslow1_q;
  reg rcslow2_q;
  reg [2:0] stage_last_q;
  wire s_acc;
  wire s_eov;
  wire s_up;
  wire s_lo;
  wire s_computation_updated_flag;
  wire [2:0] s_stage;
  wire stage_unused;
  wire wr_en;
  wire hit_stat;
  wire hit_clk;
  wire hit_ref;
  wire hit_ch;
  wire ar_take;
  assign {s_acc, s_eov, s_up, s_lo, s_computation_updated_flag, s_stage} = sync2_q;
  assign stage_unused = (s_stage == `ACS_STG_UNUSED);

  // Write channel: address and data taken in either order.
  assign do_write = (aw_hold_q | (s_axi_awvalid & s_axi_awready)) &
                    (w_hold_q | (s_axi_wvalid & s_axi_wready)) &
                    ~s_axi_bvalid;
  assign wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
  assign wr_data = w_hold_q ? wdata_q : s_axi_wdata;
  assign wr_strb = w_hold_q ? wstrb_q : s_axi_wstrb;
  assign wr_en = do_write & wr_strb[0];
  assign hit_stat = (wr_addr == `ACS_OFF_STATUS);
  assign hit_clk = (wr_addr == `ACS_OFF_CLKSEL);
  assign hit_ref = (wr_addr == `ACS_OFF_REFSEL);
  assign hit_ch = (wr_addr == `ACS_OFF_CHSEL);
  assign ar_take = s_axi_arvalid & s_axi_arready;

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `ACS_RESP_OKAY;
      aw_hold_q <= 1'b0;
      w_hold_q <= 1'b0;
      awaddr_q <= {ADDR_W{1'b0}};
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
    end else begin
      s_axi_awready <= ~aw_hold_q & ~(s_axi_awvalid & s_axi_awready) &
                       ~s_axi_bvalid & ~do_write;
      s_axi_wready <= ~w_hold_q & ~(s_axi_wvalid & s_axi_wready) &
                      ~s_axi_bvalid & ~do_write;
      if (s_axi_awvalid & s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid & s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
      end
      if (do_write) begin
        aw_hold_q <= 1'b0;
        w_hold_q <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_ok ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end else begin
        if (s_axi_awvalid & s_axi_awready) begin
          aw_hold_q <= 1'b1;
        end
        if (s_axi_wvalid & s_axi_wready) begin
          w_hold_q <= 1'b1;
        end
        if (s_axi_bvalid & s_axi_bready) begin
          s_axi_bvalid <= 1'b0;
        end
      end
    end
  end

  always @* begin
    case (wr_addr)
      `ACS_OFF_STATUS: wr_ok = 1'b1;
      `ACS_OFF_CLKSEL: wr_ok = 1'b1;
      `ACS_OFF_REFSEL: wr_ok = 1'b1;
      `ACS_OFF_CHSEL: wr_ok = 1'b1;
      `ACS_OFF_EVENTS: wr_ok = 1'b1;
      default: wr_ok = 1'b0;
    endcase
  end

  // Writing a one to the computation bit of the status register clears it; a synchronised update in the same cycle wins and keeps it set.
  assign computation_updated_flag_clr = wr_en & hit_stat & wr_data[`ACS_BIT_COMPUTATION_UPDATED_FLAG];

  // Software registers; only implemented bits store.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      clk_q <= `ACS_RESET_BYTE;
      ref_q <= `ACS_RESET_BYTE;
      ch_q <= `ACS_RESET_BYTE;
    end else if (wr_en) begin
      if (hit_clk) begin
        clk_q <= wr_data[7:0] & `ACS_MASK_CLK;
      end
      if (hit_ref) begin
        ref_q <= wr_data[7:0] & `ACS_MASK_REF;
      end
      if (hit_ch) begin
        ch_q <= wr_data[7:0] & `ACS_MASK_CH;
      end
    end
  end

  // Status register built from the synchronised computation results.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      stat_q <= `ACS_RESET_BYTE;
      computation_updated_flag_q <= 1'b0;
      computation_updated_flag_prev_q <= 1'b0;
      rcslow1_q <= 1'b0;
      rcslow2_q <= 1'b0;
      ev_q <= `ACS_RESET_BYTE;
      stage_last_q <= `ACS_STG_IDLE;
    end else begin
      computation_updated_flag_prev_q <= s_computation_updated_flag;
      rcslow1_q <= rc_slow_sysclk;
      rcslow2_q <= rcslow1_q;
      stage_last_q <= s_stage;
      if (s_computation_updated_flag) begin
        computation_updated_flag_q <= 1'b1;
      end else if (computation_updated_flag_clr) begin
        computation_updated_flag_q <= 1'b0;
      end
      if (s_computation_updated_flag & ~computation_updated_flag_prev_q) begin
        ev_q <= ev_q + 8'h01;
      end
      stat_q[`ACS_BIT_OVF] <= s_acc | s_eov;
      stat_q[`ACS_BIT_UPPER] <= s_up;
      stat_q[`ACS_BIT_LOWER] <= s_lo;
      stat_q[`ACS_BIT_COMPUTATION_UPDATED_FLAG] <= 1'b0;
      stat_q[`ACS_BIT_RSVD] <= 1'b0;
      // The stage word is taken only after it held for two cycles.
      if (s_stage == stage_last_q) begin
        if (stage_unused) begin
          stat_q[2:0] <= `ACS_STG_IDLE;
        end else begin
          stat_q[2:0] <= s_stage;
        end
      end
    end
  end

  // Read channel: one read at a time, answered one cycle after address.
  always @* begin
    rd_ok = 1'b1;
    case (s_axi_araddr)
      `ACS_OFF_STATUS: rd_d = {24'h000000,
        (stat_q | {3'h0, computation_updated_flag_q, 4'h0}) & `ACS_MASK_STAT};
      `ACS_OFF_CLKSEL: rd_d = {24'h000000, clk_q};
      `ACS_OFF_REFSEL: rd_d = {24'h000000, ref_q};
      `ACS_OFF_CHSEL: rd_d = {24'h000000, ch_q};
      `ACS_OFF_EVENTS: rd_d = {24'h000000, ev_q};
      default: begin
        rd_d = 32'h00000000;
        rd_ok = 1'b0;
      end
    endcase
  end

  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `ACS_RESP_OKAY;
    end else begin
      s_axi_arready <= ~s_axi_rvalid & ~ar_take;
      if (ar_take) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rdata <= rd_d;
        s_axi_rresp <= rd_ok ? `ACS_RESP_OKAY : `ACS_RESP_SLVERR;
      end else if (s_axi_rvalid & s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end

  // Channel decode into port group and index.
  assign ch_d = ch_q[5:0];
  assign ch_ok = (ch_d <= `ACS_CH_D_LAST) |
                 (ch_d[5:3] == 3'h4 && ch_d <= `ACS_CH_E_LAST) |
                 (ch_d >= `ACS_CH_F_FIRST && ch_d <= `ACS_CH_F_LAST) |
                 (ch_d >= `ACS_CH_GND);

  // Analog select outputs, all from flip-flops.
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      neg_ref_ext <= 1'b0;
      pos_ref_sel <= `ACS_POSITIVE_REFERENCE_SELECT_VDD;
      pos_ref_valid <= 1'b1;
      chan_sel <= 6'h00;
      chan_valid <= 1'b1;
      chan_port <= 3'h0;
      chan_index <= 3'h0;
      stage_suspect <= 1'b0;
    end else begin
      neg_ref_ext <= ref_q[`ACS_BIT_NEGATIVE_REFERENCE_SELECT];
      pos_ref_sel <= ref_q[1:0];
      pos_ref_valid <= (ref_q[1:0] != `ACS_POSITIVE_REFERENCE_SELECT_RSVD);
      chan_sel <= ch_d;
      chan_valid <= ch_ok;
      chan_port <= ch_d[5:3];
      chan_index <= ch_d[2:0];
      stage_suspect <= rcslow2_q;
    end
  end

  acs_clkdiv #(
    .SEL_W(6)
  ) u_div (
    .mclk(mclk),
    .nrst(nrst),
    .sel(clk_q[5:0]),
    .conv_clk(conv_clk),
    .conv_tick()
  );
endmodule

// ---- test/acs_top_chk.sv ----
// Port checker for the converter control block.
`timescale 1ns/1ps
module acs_top_chk #(
  parameter ADDR_W = 5
) (
  input wire mclk,
  input wire nrst,
  input wire [ADDR_W-1:0] s_axi_araddr,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  input wire [1:0] pos_ref_sel,
  input wire pos_ref_valid,
  input wire [5:0] chan_sel,
  input wire chan_valid,
  input wire [2:0] chan_port,
  input wire [2:0] chan_index
);
  reg [ADDR_W-1:0] ra_q;
  reg [7:0] keep;
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) ra_q <= {ADDR_W{1'b0}};
    else if (s_axi_arvalid && s_axi_arready) ra_q <= s_axi_araddr;
  end
  always @* begin
    case (ra_q)
      5'h00: keep = 8'hf7;
      5'h04: keep = 8'h3f;
      5'h08: keep = 8'h13;
      5'h0c: keep = 8'h3f;
      default: keep = 8'hff;
    endcase
  end
  chan_map_a: assert property (
    chan_port == chan_sel[5:3] && chan_index == chan_sel[2:0])
    else $error("channel split wrong");
  chan_valid_a: assert property (
    chan_valid == (chan_sel <= 6'h22 || chan_sel >= 6'h3c ||
    (chan_sel >= 6'h28 && chan_sel <= 6'h2f)))
    else $error("channel valid wrong");
  positive_reference_select_valid_a: assert property (
    pos_ref_valid == (pos_ref_sel != 2'h1))
    else $error("reference valid wrong");
  unused_bits_a: assert property (
    s_axi_rvalid |-> (s_axi_rdata[7:0] & ~keep) == 8'h00)
    else $error("unimplemented bit read as one");
  high_zero_a: assert property (
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  rd_latency_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  read_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped");
  resp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped");
  sel_change_a: assert property (
    $changed(chan_sel) || $changed(pos_ref_sel) |->
    $past(s_axi_bvalid) && !$past(s_axi_bvalid, 2))
    else $error("select changed without a write");
endmodule
bind acs_top acs_top_chk #(.ADDR_W(ADDR_W)) u_chk (.*);

// ---- test/tb_top.sv ----
// Self-checking bench for the converter control block.
`timescale 1ns/1ps
`define CHK(a, e) begin checked = checked + 1; if ((a) !== (e)) begin \
  mismatches = mismatches + 1; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (e)); end end
module tb_top;
  reg mclk = 0, nrst = 0, awvalid = 0, wvalid = 0, bready = 0;
  reg arvalid = 0, rready = 0, acc = 0, eov = 0, up = 0, lo = 0;
  reg mu = 0, rcs = 0;
  reg [4:0] awaddr = 0, araddr = 0;
  reg [31:0] wdata = 0, d;
  reg [2:0] stg = 0;
  reg [3:0] wstrb = 4'hf;
  reg [1:0] r;
  integer mismatches = 0, checked = 0, seed, i, p, v;
  wire awready, wready, bvalid, arready, rvalid, conv_clk, neg_ref_ext;
  wire pos_ref_valid, chan_valid, stage_suspect;
  wire [1:0] bresp, rresp, pos_ref_sel;
  wire [31:0] rdata;
  wire [5:0] chan_sel;
  wire [2:0] chan_port, chan_index;
  acs_top u_dut (.mclk(mclk), .nrst(nrst), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .acc_overflow(acc), .err_overflow(eov),
    .err_above_upper(up), .err_below_lower(lo), .computation_updated_flag_update(mu),
    .stage_code(stg), .rc_slow_sysclk(rcs), .conv_clk(conv_clk),
    .neg_ref_ext(neg_ref_ext), .pos_ref_sel(pos_ref_sel),
    .pos_ref_valid(pos_ref_valid), .chan_sel(chan_sel),
    .chan_valid(chan_valid), .chan_port(chan_port),
    .chan_index(chan_index), .stage_suspect(stage_suspect));
  initial begin
    forever #4 mclk = ~mclk;
  end
  function [31:0] sexp(input [3:0] f, input m, input [2:0] s);
    sexp = {24'h0, f[0] | f[1], f[2], f[3], m, 1'b0, s == 3'h4 ? 3'h0 : s};
  endfunction
  function chv(input [5:0] c);
    chv = c <= 6'h22 || (c >= 6'h28 && c <= 6'h2f) || c >= 6'h3c;
  endfunction
  task stop_test;
    begin
      $display("checked=%0d mismatches=%0d", checked, mismatches);
      if (mismatches == 0 && checked > 0) $display("All checks passed");
      else $display("Checks failed");
      $finish;
    end
  endtask
  task wr(input [4:0] a, input [7:0] x, output [1:0] q);
    integer n;
    begin
      q = 2'h3;
      @(posedge mclk);
      awaddr <= a;
      wdata <= {24'h0, x};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 50 && q === 2'h3; n = n + 1) begin
        @(posedge mclk);
        if (awvalid && awready) awvalid <= 1'b0;
        if (wvalid && wready) wvalid <= 1'b0;
        if (bvalid) begin
          q = bresp;
          bready <= 1'b0;
        end
      end
      if (q === 2'h3) begin
        mismatches = mismatches + 1;
        stop_test;
      end
    end
  endtask
  task rd(input [4:0] a, output [31:0] x, output [1:0] q);
    integer n;
    begin
      q = 2'h3;
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 50 && q === 2'h3; n = n + 1) begin
        @(posedge mclk);
        if (arvalid && arready) arvalid <= 1'b0;
        if (rvalid) begin
          q = rresp;
          x = rdata;
          rready <= 1'b0;
        end
      end
      if (q === 2'h3) begin
        mismatches = mismatches + 1;
        stop_test;
      end
    end
  endtask
  task rdchk(input [4:0] a, input [31:0] e);
    begin
      rd(a, d, r);
      `CHK(d, e)
      `CHK(r, 2'h0)
    end
  endtask
  task per(output integer q);
    integer n, k, m;
    reg old;
    begin
      q = -1;
      k = 0;
      old = conv_clk;
      for (n = 0; n < 600 && q < 0; n = n + 1) begin
        @(posedge mclk);
        #1;
        if (conv_clk && !old) begin
          k = k + 1;
          if (k == 2) m = n;
          if (k == 3) q = n - m;
        end
        old = conv_clk;
      end
    end
  endtask
  initial begin
    seed = 68;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    for (i = 0; i <= 16; i = i + 4) rdchk(i[4:0], 32'h0);
    rd(5'h14, d, r);
    `CHK(r, 2'h2)
    `CHK(d, 32'h0)
    wr(5'h14, 8'hff, r);
    `CHK(r, 2'h2)
    wr(5'h04, 8'hff, r);
    rdchk(5'h04, 32'h3f);
    per(v);
    `CHK(v, 128)
    wr(5'h04, 8'h00, r);
    per(v);
    `CHK(v, 2)
    p = $random(seed) & 63;
    wr(5'h04, p[7:0], r);
    per(v);
    `CHK(v, 2 * p + 2)
    for (i = 0; i < 8; i = i + 1) begin
      wr(5'h08, {3'h7, i[2], 2'h3, i[1:0]}, r);
      rdchk(5'h08, {27'h0, i[2], 2'h0, i[1:0]});
      `CHK(neg_ref_ext, i[2])
      `CHK(pos_ref_sel, i[1:0])
    end
    for (i = 0; i < 64; i = i + 1) begin
      wr(5'h0c, {2'h3, i[5:0]}, r);
      rdchk(5'h0c, {26'h0, i[5:0]});
      `CHK(chan_sel, i[5:0])
      `CHK({chan_port, chan_index}, i[5:0])
      `CHK(chan_valid, chv(i[5:0]))
    end
    wstrb <= 4'h0;
    wr(5'h0c, 8'h05, r);
    wstrb <= 4'hf;
    rdchk(5'h0c, 32'h3f);
    for (i = 0; i < 24; i = i + 1) begin
      v = $random(seed);
      @(posedge mclk);
      {lo, up, eov, acc} <= v[3:0];
      stg <= i < 8 ? i[2:0] : v[6:4];
      wr(5'h00, 8'hef, r);
      repeat (4) @(posedge mclk);
      rdchk(5'h00, sexp(v[3:0], 1'b0, stg));
    end
    {lo, up, eov, acc, stg} <= 7'h00;
    mu <= 1'b1;
    repeat (4) @(posedge mclk);
    mu <= 1'b0;
    repeat (4) @(posedge mclk);
    rdchk(5'h00, 32'h10);
    rdchk(5'h10, 32'h1);
    wr(5'h00, 8'h10, r);
    rdchk(5'h00, 32'h0);
    rcs <= 1'b1;
    repeat (5) @(posedge mclk);
    `CHK(stage_suspect, 1'b1)
    rcs <= 1'b0;
    wr(5'h04, 8'h3f, r);
    wr(5'h08, 8'h13, r);
    wr(5'h0c, 8'h3b, r);
    @(posedge mclk);
    `CHK(chan_valid, 1'b0)
    `CHK(stage_suspect, 1'b0)
    nrst <= 1'b0;
    repeat (2) @(posedge mclk);
    nrst <= 1'b1;
    repeat (2) @(posedge mclk);
    for (i = 0; i <= 16; i = i + 4) rdchk(i[4:0], 32'h0);
    `CHK(chan_valid, 1'b1)
    stop_test;
  end
endmodule
